// ===== rtl/tdcs_byte_order.sv
// Byte-order manager for 64-bit data between the bus and the kernel.
// Assumes one beat per valid; result is registered, one cycle later.
module tdcs_byte_order (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic host_big_endian,
    input wire logic reliability_table_byte_order,
    input wire logic permutation_table_halfword_order,
    input wire tdcs_pkg::tdcs_kind_t kind,
    input wire logic in_valid,
    input wire logic [63:0] in_data,
    output logic out_valid,
    output logic [63:0] out_data
);
    import tdcs_pkg::*;
    function automatic logic [2:0] src_byte(input logic [2:0] i, input tdcs_kind_t k,
        input logic be, input logic ex, input logic ip);
        logic [2:0] r;
        r = i ^ 3'h4;
        if (!be) begin
            r = i;
        end else if (k == KIND_EXTR && ex) begin
            r = 3'h7 - i;
        end else if (k == KIND_PERM && ip) begin
            r = {2'h3 - i[2:1], i[0]};
        end
        return r;
    endfunction
    logic [63:0] map_d;
    for (genvar g = 0; g < 8; g++) begin : g_lane
        logic [2:0] s;
        assign s = src_byte(3'(g), kind, host_big_endian,
            reliability_table_byte_order, permutation_table_halfword_order);
        assign map_d[g*8 +: 8] = in_data[s*8 +: 8];
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= map_d;
            end
        end
    end
endmodule

// ===== rtl/tdcs_ctrl.sv
// Command, error, status and debug-halt control of the turbo decoder.
// Assumes a synchronous config bus and a datapath that runs MAP decodes.
// Operation
// - Code four initialises, then waits in state 2.
// - Code five runs one MAP, pauses at 4.
// - Code six runs remaining MAPs, normal ending.
// - Code seven resets all but command, byte-order.
// - Extrinsic bit picks word swap or full reversal.
// - Interleaver bit picks halfword mapping, big-endian only.
// - Little-endian host leaves data untouched.
// - Any new error raises interrupt and its error bit.
// - Standalone frame length outside 40..20730 flags.
// - Shared mode frame length checked per variant.
// - Reliability length and window size checked.
// - Prolog length outside 4..48 flags error.
// - Subframe length above 5114 sets bit 4.
// - Memory touch outside debug halt sets bit 11.
// - Shared mode result read request sets bit 10.
// - Shared mode permutation load sets bit 9.
// - Bit 0 summarises any configuration error.
// - Status shows state, iteration, sub-state, half-decoder.
// - Status bit 10 shows emulation halt.
// - Bits 9..7 show awaited reads.
// - Bits 6..3 show awaited writes.
// - Bit 1 is MAP engine busy.
// - Halt point chosen by graceful select bit.
// - Halt-ignore bit lets decoding run on.
module tdcs_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [tdcs_pkg::ADDR_W-1:0] cfg_addr,
    input wire logic [tdcs_pkg::DATA_W-1:0] cfg_wdata,
    output logic [tdcs_pkg::DATA_W-1:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic host_big_endian,
    input wire logic sp_mode,
    input wire logic [1:0] seg_variant,
    input wire logic [tdcs_pkg::FL_W-1:0] frame_len,
    input wire logic [tdcs_pkg::FL_W-1:0] reliability_len,
    input wire logic [tdcs_pkg::WS_W-1:0] reliability_window_size,
    input wire logic [tdcs_pkg::PL_W-1:0] prolog_len,
    input wire logic [tdcs_pkg::SF_W-1:0] subframe_len,
    input wire logic [tdcs_pkg::IT_W-1:0] min_iter,
    input wire logic [tdcs_pkg::IT_W-1:0] max_iter,
    input wire logic [tdcs_pkg::SNR_W-1:0] snr_threshold,
    input wire logic result_param_read_req,
    input wire logic permutation_load_req,
    input wire logic map_done,
    input wire logic last_map,
    input wire logic [3:0] map_sub_state,
    input wire logic [tdcs_pkg::AW_W-1:0] await_flags,
    input wire logic crc_pass,
    input wire logic [1:0] signal_quality_result,
    input wire logic mem_touch,
    input wire logic emu_halt_req,
    output logic map_go,
    output logic map_hold,
    output logic decode_done,
    output logic soft_reset_pulse,
    output logic debug_halted_flag,
    output logic decoder_irq,
    input wire tdcs_pkg::tdcs_kind_t dat_kind,
    input wire logic dat_in_valid,
    input wire logic [63:0] dat_in,
    output logic dat_out_valid,
    output logic [63:0] dat_out
);
    import tdcs_pkg::*;

    tdcs_state_t state_q, state_d, resume_q, resume_d;
    logic [1:0] end_q;
    logic [1:0] emu_q;
    logic [2:0] cmd_q;
    logic [ERR_W-1:0] err_q, err_d;
    logic [IT_W-1:0] iter_q;
    logic map_half_q;
    logic debug_q;
    logic step_q;
    logic step_d;
    logic [ERR_W-1:0] cfg_err;

    logic wr_any;
    logic rd_any;
    logic cmd_wr;
    logic [2:0] code;
    logic go_start;
    logic go_dbg;
    logic go_step;
    logic go_run;
    logic go_srst;
    logic start_ok;
    logic halt_en;
    logic map_end;
    logic touch_ok;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rd_mux;

    tdcs_param_check u_check (
        .sp_mode(sp_mode),
        .seg_variant(seg_variant),
        .frame_len(frame_len),
        .reliability_len(reliability_len),
        .reliability_window_size(reliability_window_size),
        .prolog_len(prolog_len),
        .subframe_len(subframe_len),
        .min_iter(min_iter),
        .max_iter(max_iter),
        .snr_threshold(snr_threshold),
        .result_param_read_req(result_param_read_req),
        .permutation_load_req(permutation_load_req),
        .cfg_err(cfg_err)
    );

    tdcs_byte_order u_order (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .host_big_endian(host_big_endian),
        .reliability_table_byte_order(end_q[END_EXTR]),
        .permutation_table_halfword_order(end_q[END_INTR]),
        .kind(dat_kind),
        .in_valid(dat_in_valid),
        .in_data(dat_in),
        .out_valid(dat_out_valid),
        .out_data(dat_out)
    );

    // Bus decode
    assign wr_any = cfg_sel && cfg_wr;
    assign rd_any = cfg_sel && !cfg_wr;
    assign cmd_wr = wr_any && cfg_addr == ADDR_CMD;
    assign code = cfg_wdata[2:0];
    assign go_srst = cmd_wr && code == CMD_SOFT_RST;
    // Start only from idle; a start while busy is dropped
    assign go_start = cmd_wr && state_q == ST_IDLE && code == CMD_START;
    assign go_dbg = cmd_wr && state_q == ST_IDLE && code == CMD_DBG_INIT;
    assign go_step = cmd_wr && code == CMD_DBG_STEP;
    assign go_run = cmd_wr && code == CMD_DBG_RUN;
    assign start_ok = !cfg_err[ERRB_SUM];
    assign halt_en = emu_halt_req && !emu_q[EMU_FREE];
    assign map_end = state_q == ST_MAP && map_done;
    // Memories may only be touched while halted in debug mode
    assign touch_ok = debug_q && (emu_halt_req || state_q == ST_HALT);

    // Top-level sequencing
    always_comb begin
        state_d = state_q;
        resume_d = resume_q;
        step_d = step_q;
        unique case (state_q)
            ST_IDLE: begin
                if ((go_start || go_dbg) && start_ok) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                state_d = debug_q ? ST_DBG_WAIT : ST_MAP;
                step_d = 1'b0;
            end
            ST_DBG_WAIT, ST_MAP_PAUSE: begin
                if (go_step) begin
                    state_d = ST_MAP;
                    step_d = 1'b1;
                end else if (go_run) begin
                    state_d = ST_MAP;
                    step_d = 1'b0;
                end
            end
            ST_MAP: begin
                if (map_done) begin
                    resume_d = last_map ? ST_FINISH : (step_q ? ST_MAP_PAUSE : ST_MAP);
                    // Halt wins over MAP end when the graceful select is clear
                    state_d = (halt_en && !emu_q[EMU_SOFT]) ? ST_HALT : resume_d;
                end
            end
            ST_FINISH: begin
                if (halt_en) begin
                    state_d = ST_HALT;
                    resume_d = ST_FINISH;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (!halt_en) begin
                    state_d = resume_q;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (go_srst) begin
            state_d = ST_IDLE;
            resume_d = ST_IDLE;
            step_d = 1'b0;
        end
    end

    // Error flags: new events win over the clear of a restart or soft reset
    always_comb begin
        err_d = err_q;
        if ((go_start || go_dbg) && !go_srst) begin
            err_d = cfg_err | (err_q & ERR_W'(1 << ERRB_TOUCH));
        end
        if (go_srst) begin
            err_d = '0;
        end
        if (mem_touch && !touch_ok) begin
            err_d[ERRB_TOUCH] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            resume_q <= ST_IDLE;
            step_q <= 1'b0;
            debug_q <= 1'b0;
            err_q <= '0;
            decoder_irq <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            resume_q <= resume_d;
            step_q <= step_d;
            err_q <= err_d;
            decoder_irq <= |(err_d & ~err_q);
            if (go_start || go_dbg || go_srst) begin
                debug_q <= go_dbg;
            end
        end
    end

    // Registers kept across soft reset
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q <= CMD_NONE;
            end_q <= '0;
        end else if (ce) begin
            if (cmd_wr) begin
                cmd_q <= code;
            end
            if (wr_any && cfg_addr == ADDR_END) begin
                end_q <= cfg_wdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            emu_q <= '0;
        end else if (ce) begin
            if (go_srst) begin
                emu_q <= '0;
            end else if (wr_any && cfg_addr == ADDR_EMU) begin
                emu_q <= cfg_wdata[1:0];
            end
        end
    end

    // Iteration and half-decoder tracking
    always_ff @(posedge clk) begin
        if (srst) begin
            iter_q <= '0;
            map_half_q <= 1'b0;
        end else if (ce) begin
            if (go_srst || state_q == ST_INIT) begin
                iter_q <= '0;
                map_half_q <= 1'b0;
            end else if (map_end) begin
                map_half_q <= !map_half_q;
                if (map_half_q && iter_q != '1) begin
                    iter_q <= iter_q + IT_W'(1);
                end
            end
        end
    end

    // Datapath handshakes
    always_ff @(posedge clk) begin
        if (srst) begin
            map_go <= 1'b0;
            decode_done <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else if (ce) begin
            map_go <= state_d == ST_MAP && (state_q != ST_MAP || map_done);
            decode_done <= state_q == ST_FINISH && state_d == ST_IDLE;
            soft_reset_pulse <= go_srst;
        end
    end

    // Datapath stalls in its current MAP state while held
    assign map_hold = state_q == ST_DBG_WAIT || state_q == ST_MAP_PAUSE || state_q == ST_HALT;
    assign debug_halted_flag = state_q == ST_HALT;

    always_comb begin
        stat_word = REG_RST;
        stat_word[27:24] = 4'(state_q);
        stat_word[23] = crc_pass;
        stat_word[22:21] = signal_quality_result;
        stat_word[20:16] = iter_q;
        stat_word[15:12] = map_sub_state;
        stat_word[11] = map_half_q;
        stat_word[10] = debug_halted_flag;
        stat_word[9:3] = await_flags;
        stat_word[2] = err_q[ERRB_SUM];
        stat_word[1] = map_sub_state != 4'h0;
    end

    // Command register is write-only; unmapped reads return zero
    assign rd_mux = cfg_addr == ADDR_STAT ? stat_word
        : cfg_addr == ADDR_ERR ? DATA_W'(err_q)
        : cfg_addr == ADDR_END ? DATA_W'(end_q)
        : cfg_addr == ADDR_EMU ? DATA_W'(emu_q) : REG_RST;

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_rdata <= REG_RST;
            cfg_rvalid <= 1'b0;
        end else if (ce) begin
            cfg_rvalid <= rd_any;
            if (rd_any) begin
                cfg_rdata <= rd_mux;
            end
        end
    end

    start_run_a: assert property (@(posedge clk) disable iff (srst)
        ce && go_start && start_ok |=> state_q == ST_INIT ##1 (!ce || state_q == ST_MAP))
        else $error("start did not launch decode");
    idle_none_a: assert property (@(posedge clk) disable iff (srst)
        ce && state_q == ST_IDLE && !(go_start || go_dbg) |=> state_q == ST_IDLE)
        else $error("idle left without start");
    dbg_wait_a: assert property (@(posedge clk) disable iff (srst)
        ce && go_dbg && start_ok |=> ##1 (!ce || (state_q == ST_DBG_WAIT && map_hold)))
        else $error("debug init did not wait");
    step_pause_a: assert property (@(posedge clk) disable iff (srst)
        ce && map_end && step_q && !last_map && !halt_en && !go_srst
        |=> state_q == ST_MAP_PAUSE && map_hold)
        else $error("single step did not pause");
    run_rest_a: assert property (@(posedge clk) disable iff (srst)
        ce && state_q == ST_MAP_PAUSE && go_run |=> state_q == ST_MAP && !step_q && map_go)
        else $error("run rest did not resume");
    soft_rst_a: assert property (@(posedge clk) disable iff (srst)
        ce && go_srst |=> err_q == {3'h0, $past(mem_touch && !touch_ok), 11'h000} && emu_q == '0
        && state_q == ST_IDLE && end_q == $past(end_q) && soft_reset_pulse)
        else $error("soft reset wrong");
    err_irq_a: assert property (@(posedge clk) disable iff (srst)
        ce && (err_d & ~err_q) != '0 |=> decoder_irq && err_q != '0)
        else $error("error without interrupt");
    frame_err_a: assert property (@(posedge clk) disable iff (srst)
        ce && go_start && !go_srst && cfg_err[ERRB_F] |=> err_q[ERRB_F] && err_q[ERRB_SUM])
        else $error("frame length error lost");
    touch_err_a: assert property (@(posedge clk) disable iff (srst)
        ce && mem_touch && !touch_ok |=> err_q[ERRB_TOUCH])
        else $error("memory touch error lost");
    busy_bit_a: assert property (@(posedge clk) disable iff (srst)
        ce && rd_any && cfg_addr == ADDR_STAT |=> cfg_rdata[1] == ($past(map_sub_state) != 4'h0))
        else $error("busy bit mismatch");
    free_run_a: assert property (@(posedge clk) disable iff (srst)
        emu_q[EMU_FREE] && state_q != ST_HALT |=> state_q != ST_HALT)
        else $error("halted while ignoring halt");
    soft_point_a: assert property (@(posedge clk) disable iff (srst)
        ce && map_end && !last_map && emu_q[EMU_SOFT] && !go_srst |=> state_q != ST_HALT)
        else $error("graceful halt taken at MAP end");

    start_cov: cover property (@(posedge clk) disable iff (srst) go_start && start_ok);
    step_cov: cover property (@(posedge clk) disable iff (srst) state_q == ST_MAP_PAUSE && go_step);
    halt_cov: cover property (@(posedge clk) disable iff (srst) state_q == ST_HALT && !halt_en);
endmodule

// ===== rtl/tdcs_param_check.sv
// Validates the frame configuration; purely combinational flags.
// Assumes parameter inputs are stable while a start command is taken.
module tdcs_param_check (
    input wire logic sp_mode,
    input wire logic [1:0] seg_variant,
    input wire logic [tdcs_pkg::FL_W-1:0] frame_len,
    input wire logic [tdcs_pkg::FL_W-1:0] reliability_len,
    input wire logic [tdcs_pkg::WS_W-1:0] reliability_window_size,
    input wire logic [tdcs_pkg::PL_W-1:0] prolog_len,
    input wire logic [tdcs_pkg::SF_W-1:0] subframe_len,
    input wire logic [tdcs_pkg::IT_W-1:0] min_iter,
    input wire logic [tdcs_pkg::IT_W-1:0] max_iter,
    input wire logic [tdcs_pkg::SNR_W-1:0] snr_threshold,
    input wire logic result_param_read_req,
    input wire logic permutation_load_req,
    output logic [tdcs_pkg::ERR_W-1:0] cfg_err
);
    import tdcs_pkg::*;
    logic v3;
    logic f_sa;
    logic f_sp;
    logic r_bad;
    logic [ERR_W-1:0] raw;
    assign v3 = seg_variant == SEG_V3;
    assign f_sa = frame_len < FL_SA_MIN || frame_len > FL_SA_MAX;
    // Variant 3 drops the 256 granularity
    assign f_sp = v3 ? (frame_len < FL_SP3_MIN || frame_len > FL_SP_MAX)
        : (frame_len < FL_SP12_MIN || frame_len > FL_SP_MAX || frame_len[7:0] != 8'h00);
    assign r_bad = reliability_len < RL_MIN
        || (sp_mode && !v3 && reliability_window_size != WS_SP12)
        || (sp_mode && v3 && reliability_window_size < WS_SP3_MIN);
    always_comb begin
        raw = '0;
        raw[ERRB_F] = sp_mode ? f_sp : f_sa;
        raw[ERRB_P] = prolog_len < PL_MIN || prolog_len > PL_MAX;
        raw[ERRB_SF] = subframe_len > SF_MAX;
        raw[ERRB_R] = r_bad;
        raw[ERRB_SNR] = snr_threshold > SNR_MAX;
        raw[ERRB_MM] = min_iter > max_iter;
        raw[ERRB_RESULT] = sp_mode && result_param_read_req;
        raw[ERRB_INT] = sp_mode && permutation_load_req;
        cfg_err = raw;
        cfg_err[ERRB_SUM] = |raw;
    end
endmodule

// ===== rtl/tdcs_pkg.sv
// Constants, field layout and types of the decoder control/status block.
// Assumes a 32-bit configuration bus with word-aligned byte addresses.
package tdcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FL_W = 15;
    localparam int WS_W = 8;
    localparam int PL_W = 6;
    localparam int SF_W = 13;
    localparam int IT_W = 5;
    localparam int SNR_W = 7;
    localparam int AW_W = 7;
    localparam int ERR_W = 15;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_END = 8'h64;
    localparam logic [ADDR_W-1:0] ADDR_ERR = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h6c;
    localparam logic [ADDR_W-1:0] ADDR_EMU = 8'h70;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_START = 3'h1;
    localparam logic [2:0] CMD_DBG_INIT = 3'h4;
    localparam logic [2:0] CMD_DBG_STEP = 3'h5;
    localparam logic [2:0] CMD_DBG_RUN = 3'h6;
    localparam logic [2:0] CMD_SOFT_RST = 3'h7;
    localparam int END_INTR = 0;
    localparam int END_EXTR = 1;
    localparam int EMU_FREE = 0;
    localparam int EMU_SOFT = 1;
    localparam int ERRB_SUM = 0;
    localparam int ERRB_F = 1;
    localparam int ERRB_P = 2;
    localparam int ERRB_SF = 4;
    localparam int ERRB_R = 7;
    localparam int ERRB_SNR = 8;
    localparam int ERRB_INT = 9;
    localparam int ERRB_RESULT = 10;
    localparam int ERRB_TOUCH = 11;
    localparam int ERRB_MM = 14;
    localparam logic [FL_W-1:0] FL_SA_MIN = 15'h0028;
    localparam logic [FL_W-1:0] FL_SA_MAX = 15'h50fa;
    localparam logic [FL_W-1:0] FL_SP12_MIN = 15'h0100;
    localparam logic [FL_W-1:0] FL_SP_MAX = 15'h5000;
    localparam logic [FL_W-1:0] FL_SP3_MIN = 15'h0080;
    localparam logic [FL_W-1:0] RL_MIN = 15'h0028;
    localparam logic [WS_W-1:0] WS_SP12 = 8'h80;
    localparam logic [WS_W-1:0] WS_SP3_MIN = 8'h41;
    localparam logic [PL_W-1:0] PL_MIN = 6'h04;
    localparam logic [PL_W-1:0] PL_MAX = 6'h30;
    localparam logic [SF_W-1:0] SF_MAX = 13'h13fa;
    localparam logic [SNR_W-1:0] SNR_MAX = 7'h64;
    localparam logic [1:0] SEG_V3 = 2'h3;
    localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;
    typedef enum logic [1:0] {KIND_PLAIN, KIND_EXTR, KIND_PERM} tdcs_kind_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_INIT, ST_DBG_WAIT, ST_MAP, ST_MAP_PAUSE, ST_FINISH, ST_HALT
    } tdcs_state_t;
endpackage

// ===== sim/tb_turbo_decoder_ctrl_status.sv
// Self-checking bench of the control/status block with a MAP datapath model.
// Assumes one 200 MHz clock and inputs driven on the falling edge.
module tb_turbo_decoder_ctrl_status;
    timeunit 1ns;
    timeprecision 1ps;
    import tdcs_pkg::*;
    logic clk = 0, srst = 1, ce = 1, cfg_sel = 0, cfg_wr = 0, host_big_endian = 0, sp_mode = 0;
    logic [ADDR_W-1:0] cfg_addr = '0;
    logic [DATA_W-1:0] cfg_wdata = '0, cfg_rdata;
    logic [1:0] seg_variant = 2'h1, sq = 2'h2;
    logic [FL_W-1:0] frame_len = 15'h0064, rel_len = 15'h0028;
    logic [SF_W-1:0] subframe_len = '0;
    logic [AW_W-1:0] aw = '0;
    logic crc = 1, rp_req = 0, pl_req = 0, mem_touch = 0, emu_halt = 0, dat_v = 0;
    logic cfg_rvalid, map_go, map_hold, done, srp, halted, irq, map_done, last_map, dov;
    logic [3:0] sub;
    logic [63:0] dat_in = '0, dat_out;
    logic [15:0] seed = 16'h0003;
    tdcs_kind_t kind = KIND_PLAIN;
    logic [63:0] rq[$], dq[$];
    int n_mismatch = 0, check_count = 0, irq_cnt = 0, done_cnt = 0;
    tdcs_ctrl tdcs_ctrl_i (.clk(clk), .srst(srst), .ce(ce), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .host_big_endian(host_big_endian), .sp_mode(sp_mode), .seg_variant(seg_variant),
        .frame_len(frame_len), .reliability_len(rel_len), .reliability_window_size(8'h80),
        .prolog_len(6'h18), .subframe_len(subframe_len), .min_iter(5'h01), .max_iter(5'h08),
        .snr_threshold(7'h00), .result_param_read_req(rp_req), .permutation_load_req(pl_req),
        .map_done(map_done), .last_map(last_map), .map_sub_state(sub), .await_flags(aw),
        .crc_pass(crc), .signal_quality_result(sq), .mem_touch(mem_touch), .emu_halt_req(emu_halt),
        .map_go(map_go), .map_hold(map_hold), .decode_done(done), .soft_reset_pulse(srp),
        .debug_halted_flag(halted), .decoder_irq(irq), .dat_kind(kind), .dat_in_valid(dat_v),
        .dat_in(dat_in), .dat_out_valid(dov), .dat_out(dat_out));
    tdcs_map_model tdcs_map_model_i (.clk(clk), .srst(srst), .map_go(map_go), .map_done(map_done),
        .last_map(last_map), .map_sub_state(sub));
    always #2.5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Bus tasks leave the select up; idle() drops it so back-to-back access is legal
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cfg_sel = 1; cfg_wr = 1; cfg_addr = a; cfg_wdata = d;
        @(negedge clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rq.push_back({32'h0000_0000, e});
        cfg_sel = 1; cfg_wr = 0; cfg_addr = a;
        @(negedge clk);
    endtask
    task automatic send(input tdcs_kind_t k, input logic [63:0] e);
        kind = k; dat_v = 1; dq.push_back(e);
        @(negedge clk);
    endtask
    task automatic idle(input int n);
        cfg_sel = 0; dat_v = 0;
        repeat (n) @(negedge clk);
    endtask
    always @(posedge clk) begin
        if (cfg_rvalid === 1'b1 && rq.size() > 0) check(cfg_rdata, rq.pop_front());
        if (dov === 1'b1 && dq.size() > 0) check(dat_out, dq.pop_front());
        if (irq === 1'b1) irq_cnt++;
        if (done === 1'b1) done_cnt++;
    end
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        logic [63:0] x;
        aw = 7'h5a;
        repeat (12) @(negedge clk);
        srst = 0;
        rd(ADDR_STAT, {8'h00, crc, sq, 5'h00, 4'h0, 2'b00, aw, 3'b000});
        rd(ADDR_ERR, 32'h0000_0000);
        rd(ADDR_EMU, 32'h0000_0000);
        rd(ADDR_END, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rd(ADDR_CMD, 32'h0000_0000);
        wr(ADDR_END, 32'h0000_0003);
        wr(ADDR_EMU, 32'hffff_fffd);
        rd(ADDR_EMU, 32'h0000_0001);
        frame_len = 15'h000a;
        wr(ADDR_CMD, {29'h0, CMD_START});
        idle(4);
        rd(ADDR_ERR, 32'h0000_0003);
        idle(3);
        check(irq_cnt, 1);
        sp_mode = 1;
        rp_req = 1;
        pl_req = 1;
        wr(ADDR_CMD, {29'h0, CMD_START});
        idle(1);
        rd(ADDR_ERR, 32'h0000_0603);
        sp_mode = 0;
        wr(ADDR_CMD, {29'h0, CMD_SOFT_RST});
        idle(2);
        ce = 0;
        wr(ADDR_END, 32'h0000_0000);
        ce = 1;
        rd(ADDR_ERR, 32'h0000_0000);
        rd(ADDR_END, 32'h0000_0003);
        frame_len = 15'h0064;
        wr(ADDR_CMD, {29'h0, CMD_NONE});
        wr(ADDR_CMD, {29'h0, CMD_START});
        idle(1);
        for (int i = 0; i < 300 && done_cnt == 0; i++) @(negedge clk);
        check(done_cnt, 1);
        rd(ADDR_STAT, {8'h00, crc, sq, 5'h02, 4'h0, 2'b00, aw, 3'b000});
        wr(ADDR_CMD, {29'h0, CMD_DBG_INIT});
        idle(3);
        rd(ADDR_STAT, {8'h02, crc, sq, 5'h00, 4'h0, 2'b00, aw, 3'b000});
        emu_halt = 1;
        mem_touch = 1;
        idle(1);
        mem_touch = 0;
        emu_halt = 0;
        rd(ADDR_ERR, 32'h0000_0000);
        mem_touch = 1;
        idle(1);
        mem_touch = 0;
        rd(ADDR_ERR, 32'h0000_0800);
        wr(ADDR_CMD, {29'h0, CMD_DBG_STEP});
        idle(12);
        rd(ADDR_STAT, {8'h04, crc, sq, 5'h00, 4'h0, 2'b10, aw, 3'b000});
        emu_halt = 1;
        wr(ADDR_CMD, {29'h0, CMD_DBG_RUN});
        idle(12);
        check(halted, 1);
        emu_halt = 0;
        for (int i = 0; i < 300 && done_cnt == 1; i++) @(negedge clk);
        check(done_cnt, 2);
        wr(ADDR_EMU, 32'h0000_0001);
        emu_halt = 1;
        wr(ADDR_CMD, {29'h0, CMD_START});
        idle(1);
        for (int i = 0; i < 300 && done_cnt == 2; i++) @(negedge clk);
        check(done_cnt, 3);
        host_big_endian = 1;
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < 4; j++) begin
                seed = lfsr(seed);
                x[j*16+:16] = seed;
            end
            dat_in = x;
            if (i % 3 == 0) send(KIND_PLAIN, {x[31:0], x[63:32]});
            if (i % 3 == 1) send(KIND_EXTR, {<<8{x}});
            if (i % 3 == 2) send(KIND_PERM, {x[15:0], x[31:16], x[47:32], x[63:48]});
        end
        idle(1);
        wr(ADDR_END, 32'h0000_0000);
        idle(1);
        send(KIND_EXTR, {x[31:0], x[63:32]});
        send(KIND_PERM, {x[31:0], x[63:32]});
        host_big_endian = 0;
        send(KIND_PERM, x);
        idle(4);
        check(rq.size() + dq.size(), 0);
        end_sim();
    end
endmodule

// ===== sim/tdcs_map_model.sv
// Behavioural MAP datapath: answers each map_go with map_done a few cycles later.
// Assumes the control block pulses map_go once per MAP decode.
module tdcs_map_model #(
    parameter int NMAP = 4,
    parameter int LAT = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic map_go,
    output logic map_done,
    output logic last_map,
    output logic [3:0] map_sub_state
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    int maps_q;
    assign map_sub_state = (cnt_q != 0) ? 4'h3 : 4'h0;
    // Count has already wrapped while the last MAP's done stands
    assign last_map = map_done && maps_q == 0;
    always @(posedge clk) begin
        map_done <= 1'b0;
        if (srst) begin
            cnt_q <= 0;
            maps_q <= 0;
        end else if (map_go) begin
            cnt_q <= LAT;
        end else if (cnt_q == 1) begin
            cnt_q <= 0;
            map_done <= 1'b1;
            maps_q <= (maps_q == NMAP - 1) ? 0 : maps_q + 1;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule
